//--- rtl/pcs_consts.svh
// constants of the paged control slave: address prefix, offsets, resets
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_ADDR_PREFIX 5'h13
`define PCS_REG_PAGE_SEL 7'h00
`define PCS_PAGE_SEL_RST 8'h00
`define PCS_INDEX_MAX 7'h7f
`define PCS_INDEX_RST 7'h00
`define PCS_BIT_CNT_LAST 3'h7
`endif

//--- rtl/pcs_i2c_slave.sv
// i2c slave control port with paged registers and auto-increment index
`include "pcs_consts.svh"
// Notes on behaviour
// - slave only; sampling at 25 MHz covers standard and fast timing.
// - never makes start, stop or clock; drives only data low.
// - decode start, address, direction, ack, bytes with acks, stop.
// - read: device sends bytes; master nacks last and stops.
// - seven bit address with fixed upper prefix 10011.
// - two low address bits come from two strap pins.
// - low strap high gives 0x9A write; high strap only gives 0x9C.
// - write addresses 0x98, 0x9A, 0x9C, 0x9E; four devices per bus.
// - acknowledge only own address; ignore other transactions.
// - register zero selects page 0 to 255 for later accesses; one page backs all numbers, so the page only drives page_select_o and register zero reads.
// - with auto-increment a run of registers moves in one transaction.
// - first write byte holds increment flag and start register index.
// - with the flag set, index increments per byte, wrapping 0x7F to 0x0.
// - read: write index, repeated start, read from indexed register.
module pcs_i2c_slave (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_strap_low_pin_i,
	input wire logic addr_strap_high_pin_i,
	output pcs_pkg::pcs_page_t page_select_o,
	output logic busy_o
);
	import pcs_pkg::*;

	// ===========================================================
	// pin synchronisers
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic [1:0] strap_lo_s;
	logic [1:0] strap_hi_s;
	logic scl_d;
	logic sda_d;
	// two flops before any logic looks at a pin
	always_ff @(posedge core_clk_i) begin
		scl_s <= {scl_s[0], scl_i};
		sda_s <= {sda_s[0], sda_i};
		strap_lo_s <= {strap_lo_s[0], addr_strap_low_pin_i};
		strap_hi_s <= {strap_hi_s[0], addr_strap_high_pin_i};
		scl_d <= scl_s[1];
		sda_d <= sda_s[1];
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_s[1] & ~scl_d;
	assign scl_fall = ~scl_s[1] & scl_d;
	// data moving while clock is high marks start or stop
	assign start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	assign stop_det = scl_s[1] & scl_d & ~sda_d & sda_s[1];

	// ===========================================================
	// strap capture: held in reset and one cycle after, then frozen
	logic [1:0] strap;
	logic strap_lock;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			strap_lock <= 1'b0;
		end else begin
			strap_lock <= 1'b1;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!strap_lock) begin
			strap <= {strap_hi_s[1], strap_lo_s[1]};
		end
	end
	logic [6:0] own_addr;
	assign own_addr = {`PCS_ADDR_PREFIX, strap};

	// ===========================================================
	// frame engine
	pcs_state_e state;
	logic [2:0] bit_cnt;
	pcs_byte_t shreg;
	logic rd_dir;
	logic first_byte;
	logic auto_inc;
	pcs_index_t index;
	pcs_page_t page;
	logic master_ack;
	pcs_regbus_if rbus ();

	pcs_reg_store u_store (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.bus(rbus.store)
	);

	logic byte_done;
	logic wr_data;
	logic addr_hit;
	logic ack_seen;
	logic ack_end;
	pcs_index_t index_inc;
	assign byte_done = scl_rise && bit_cnt == `PCS_BIT_CNT_LAST;
	// shreg still holds the seven address bits on the byte_done edge
	assign addr_hit = shreg[6:0] == own_addr;
	// an ack state spans the ninth clock and ends on the fall after it
	assign ack_end = scl_fall && ack_seen;
	assign wr_data = state == PCS_WR_ACK && ack_end && !first_byte;
	// 7 bit index wraps naturally from 7F to 00
	assign index_inc = index + 7'h01;

	assign rbus.wr_en = wr_data;
	assign rbus.page = page;
	assign rbus.index = index;
	assign rbus.wdata = shreg;

	// ninth clock seen in an ack state; leaving early would count it as data
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || start_det || stop_det || scl_fall) begin
			ack_seen <= 1'b0;
		end else if (scl_rise && (state == PCS_ADDR_ACK ||
			state == PCS_WR_ACK || state == PCS_RD_ACK)) begin
			ack_seen <= 1'b1;
		end
	end

	// state sequencing on clock edges; start or stop aborts anything
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || stop_det) begin
			state <= PCS_IDLE;
		end else if (start_det) begin
			state <= PCS_ADDR; // repeated start reenters here
		end else begin
			unique case (state)
				PCS_IDLE: state <= PCS_IDLE;
				PCS_ADDR: if (byte_done) begin
					// foreign address: go quiet until next start
					if (addr_hit)
						state <= PCS_ADDR_ACK;
					else
						state <= PCS_IDLE;
				end
				PCS_ADDR_ACK: if (ack_end) begin
					state <= rd_dir ? PCS_RD_BYTE : PCS_WR_BYTE;
				end
				PCS_WR_BYTE: if (byte_done) state <= PCS_WR_ACK;
				PCS_WR_ACK: if (ack_end) state <= PCS_WR_BYTE;
				PCS_RD_BYTE: if (byte_done) state <= PCS_RD_ACK;
				PCS_RD_ACK: if (ack_end) begin
					// nack ends the read; wait for stop
					state <= master_ack ? PCS_RD_BYTE : PCS_IDLE;
				end
				default: state <= PCS_IDLE;
			endcase
		end
	end

	// bit counter and receive shifter
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || start_det) begin
			bit_cnt <= 3'h0;
		end else if (scl_rise && (state == PCS_ADDR ||
			state == PCS_WR_BYTE || state == PCS_RD_BYTE)) begin
			bit_cnt <= bit_cnt + 3'h1;
			shreg <= {shreg[6:0], sda_s[1]};
		end else if (state == PCS_RD_ACK && scl_rise) begin
			master_ack <= ~sda_s[1];
		end
	end

	// direction latched with the address byte
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rd_dir <= 1'b0;
		end else if (state == PCS_ADDR && byte_done) begin
			rd_dir <= sda_s[1];
		end
	end

	// index, increment flag and page selector
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			index <= `PCS_INDEX_RST;
			auto_inc <= 1'b0;
			first_byte <= 1'b0;
			page <= `PCS_PAGE_SEL_RST;
		end else begin
			if (state == PCS_ADDR_ACK && ack_end) begin
				first_byte <= 1'b1;
			end
			if (state == PCS_WR_ACK && ack_end) begin
				first_byte <= 1'b0;
				if (first_byte) begin
					auto_inc <= shreg[7];
					index <= shreg[6:0];
				end else begin
					if (index == `PCS_REG_PAGE_SEL) page <= shreg;
					if (auto_inc) index <= index_inc;
				end
			end
			// read pointer moves as the byte completes, before the next load
			if (state == PCS_RD_BYTE && byte_done && auto_inc) begin
				index <= index_inc;
			end
		end
	end

	// ===========================================================
	// data line drive: open drain, only pulls low
	logic load_rd;
	pcs_byte_t tx;
	assign load_rd = ack_end && (state == PCS_ADDR_ACK && rd_dir ||
		state == PCS_RD_ACK && master_ack);
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tx <= 8'h00;
		end else if (load_rd) begin
			tx <= rbus.rdata;
		end else if (state == PCS_RD_BYTE && scl_fall) begin
			tx <= {tx[6:0], 1'b1};
		end
	end

	// ack pull-down or read bit; released on every other slot
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || start_det || stop_det) begin
			sda_oe_o <= 1'b0;
		end else if (scl_fall) begin
			// first fall in the address or write ack state opens the ack slot
			if (state == PCS_ADDR_ACK && !ack_seen)
				sda_oe_o <= 1'b1;
			else if (state == PCS_WR_ACK && !ack_seen)
				sda_oe_o <= 1'b1;
			else if (load_rd)
				sda_oe_o <= ~rbus.rdata[7];
			else if (state == PCS_RD_BYTE && bit_cnt != 3'h0)
				sda_oe_o <= ~tx[6];
			else
				sda_oe_o <= 1'b0;
		end
	end
	assign sda_o = 1'b0;

	assign page_select_o = page;
	assign busy_o = state != PCS_IDLE;

	// ===========================================================
	// checks
	a_no_ack_idle: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		state == PCS_IDLE && $past(state) == PCS_IDLE |-> !sda_oe_o)
		else $error("data line driven while idle");
	a_addr_fixed: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		strap_lock && $past(strap_lock) |-> $stable(own_addr))
		else $error("slave address moved");
	a_prefix_hold: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) own_addr[6:2] == 5'h13)
		else $error("address prefix wrong");
	a_index_wrap: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		wr_data && auto_inc && index == 7'h7f |=> index == 7'h00)
		else $error("index did not wrap");
	a_page_write: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		wr_data && index == 7'h00 |=> page == $past(shreg))
		else $error("page select not stored");
	a_stop_idle: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) stop_det |=> state == PCS_IDLE)
		else $error("stop not honoured");
	a_nack_ends: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		state == PCS_RD_ACK && ack_end && !master_ack |=>
		state == PCS_IDLE)
		else $error("read continued after nack");
	a_addr_ack: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		state == PCS_ADDR_ACK && scl_fall && !ack_seen |=> sda_oe_o)
		else $error("own address not acknowledged");
	a_start_addr: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) start_det && !stop_det |=> state == PCS_ADDR)
		else $error("start not decoded");
	c_write: cover property (@(posedge core_clk_i) wr_data);
	c_read: cover property (@(posedge core_clk_i) load_rd);
	c_wrap: cover property (@(posedge core_clk_i)
		wr_data && index == 7'h7f);
endmodule : pcs_i2c_slave

//--- rtl/pcs_pkg.sv
// types shared by the paged control slave
package pcs_pkg;
	typedef logic [7:0] pcs_byte_t;
	typedef logic [6:0] pcs_index_t;
	typedef logic [7:0] pcs_page_t;
	typedef enum logic [2:0] {
		PCS_IDLE = 3'b000,
		PCS_ADDR = 3'b001,
		PCS_ADDR_ACK = 3'b010,
		PCS_WR_BYTE = 3'b011,
		PCS_WR_ACK = 3'b100,
		PCS_RD_BYTE = 3'b101,
		PCS_RD_ACK = 3'b110
	} pcs_state_e;
endpackage : pcs_pkg

//--- rtl/pcs_reg_store.sv
// register store: one 128 byte page array, page select at index zero
`include "pcs_consts.svh"
module pcs_reg_store (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	pcs_regbus_if.store bus
);
	import pcs_pkg::*;
	// one physical page backs every page number; only the selector differs
	pcs_byte_t mem [0:127];

	// ===========================================================
	// storage
	always_ff @(posedge core_clk_i) begin
		// writes held off while reset is applied
		if (!sys_rst_i && bus.wr_en && bus.index != `PCS_REG_PAGE_SEL) begin
			mem[bus.index] <= bus.wdata;
		end
	end

	// read mux: page select comes from the engine's register
	always_comb begin
		if (bus.index == `PCS_REG_PAGE_SEL) begin
			bus.rdata = bus.page;
		end else begin
			bus.rdata = mem[bus.index];
		end
	end
endmodule : pcs_reg_store

//--- rtl/pcs_regbus_if.sv
// register access channel between the bus engine and the register store
interface pcs_regbus_if;
	import pcs_pkg::*;
	logic wr_en;
	pcs_page_t page;
	pcs_index_t index;
	pcs_byte_t wdata;
	pcs_byte_t rdata;
	modport engine (output wr_en, output page, output index, output wdata,
		input rdata);
	modport store (input wr_en, input page, input index, input wdata,
		output rdata);
endinterface : pcs_regbus_if

//--- verif/pcs_master_model.sv
// partner model: i2c bus master that makes the clock and pulls data low
module pcs_master_model (
	input wire logic core_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic in_frame = 1'b0;
	// ==========
	// bus idles released and still; each phase is whole core clocks
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : wait_clk
	// data moves mid low phase, so no false start or stop is seen
	task automatic bit_slot(input logic b, output logic r);
		scl_o = 1'b0;
		wait_clk(2);
		sda_low_o = !b;
		wait_clk(2);
		scl_o = 1'b1;
		wait_clk(4);
		r = sda_i;
	endtask : bit_slot
	// start or repeated start opens every packet
	task automatic start();
		if (in_frame) begin
			scl_o = 1'b0;
			wait_clk(2);
			sda_low_o = 1'b0;
			wait_clk(2);
			scl_o = 1'b1;
			wait_clk(4);
		end
		sda_low_o = 1'b1;
		wait_clk(4);
		in_frame = 1'b1;
	endtask : start
	// stop closes the packet and releases the line to its pull-up
	task automatic stop();
		scl_o = 1'b0;
		wait_clk(2);
		sda_low_o = 1'b1;
		wait_clk(2);
		scl_o = 1'b1;
		wait_clk(4);
		sda_low_o = 1'b0;
		wait_clk(4);
		in_frame = 1'b0;
	endtask : stop
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
		bit_slot(1'b1, r);
		ack = !r;
	endtask : wr_byte
	// master answers the last read byte with a nack
	task automatic rd_byte(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
		bit_slot(nak, r);
	endtask : rd_byte
endmodule : pcs_master_model

//--- verif/tb.sv
// testbench of the paged i2c control slave
`include "pcs_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pcs_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b0;
	logic [1:0] strap = 2'b01;
	wire logic scl;
	wire logic m_low;
	wire logic sda;
	logic sda_o;
	logic sda_oe_o;
	pcs_page_t page_select_o;
	logic busy_o;
	logic [7:0] own;
	int failures = 0;
	int checks = 0;
	// ==========
	// 25 MHz clock; open-drain data line with a pull-up
	always #20 core_clk_i = !core_clk_i;
	assign sda = !(m_low || (sda_oe_o && !sda_o));
	pcs_i2c_slave uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.addr_strap_low_pin_i(strap[0]), .addr_strap_high_pin_i(strap[1]),
		.page_select_o(page_select_o), .busy_o(busy_o));
	pcs_master_model m (.core_clk_i(core_clk_i), .sda_i(sda),
		.scl_o(scl), .sda_low_o(m_low));
	// ==========
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	// straps are taken while reset is held
	task automatic do_reset(input logic [1:0] s);
		strap = s;
		sys_rst_i = 1'b1;
		repeat (5) @(posedge core_clk_i);
		#1;
		sys_rst_i = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#1;
		own = {`PCS_ADDR_PREFIX, s, 1'b0};
	endtask : do_reset
	task automatic wr_regs(input pcs_byte_t idx, input pcs_byte_t d[$]);
		logic a;
		logic ok = 1'b1;
		m.start();
		m.wr_byte(own, a);
		ok &= a;
		m.wr_byte(idx, a);
		ok &= a;
		foreach (d[i]) begin
			m.wr_byte(d[i], a);
			ok &= a;
		end
		m.stop();
		chk("write acks", 8'h01, {7'h00, ok});
	endtask : wr_regs
	task automatic rd_regs(input pcs_byte_t idx, input pcs_byte_t e[$]);
		logic a;
		pcs_byte_t d;
		m.start();
		m.wr_byte(own, a);
		m.wr_byte(idx, a);
		m.start();
		m.wr_byte(own | 8'h01, a);
		chk("read addr ack", 8'h01, {7'h00, a});
		foreach (e[i]) begin
			m.rd_byte(i == e.size() - 1, d);
			chk("read data", e[i], d);
		end
		m.stop();
	endtask : rd_regs
	// ==========
	// probe all four addresses under each strap setting
	task automatic t_address();
		logic a;
		logic [7:0] b;
		for (int s = 0; s < 4; s++) begin
			do_reset(s[1:0]);
			chk("reset page", 8'h00, page_select_o);
			chk("reset busy", 8'h00, {6'h00, busy_o, sda_oe_o});
			strap = ~s[1:0];
			for (int t = 0; t < 4; t++) begin
				b = {`PCS_ADDR_PREFIX, t[1:0], 1'b0};
				m.start();
				m.wr_byte(b, a);
				chk("addr ack", {7'h00, t == s}, {7'h00, a});
				if (t == s) chk("busy", 8'h01, {7'h00, busy_o});
				m.stop();
				if (t == s) chk("idle", 8'h00, {7'h00, busy_o});
			end
		end
		do_reset(2'b01);
		// literal write address with the low strap high, high strap low
		m.start();
		m.wr_byte(8'h9a, a);
		m.stop();
		chk("addr 9a ack", 8'h01, {7'h00, a});
	endtask : t_address
	// page select takes 0xff and 0xa5, and 0xa5 reads back
	task automatic t_page();
		pcs_byte_t v[$] = '{8'hff, 8'ha5};
		foreach (v[i]) begin
			wr_regs(8'h80, '{v[i]});
			chk("page", v[i], page_select_o);
		end
		rd_regs(8'h80, '{8'ha5});
	endtask : t_page
	// run over the top of the index wraps into the page select
	task automatic t_wrap();
		wr_regs(8'hfe, '{8'h11, 8'h22, 8'h33});
		chk("wrapped page", 8'h33, page_select_o);
		rd_regs(8'hfe, '{8'h11, 8'h22, 8'h33});
	endtask : t_wrap
	// without the flag the index holds, so the last byte wins
	task automatic t_noinc();
		wr_regs(8'h05, '{8'h44, 8'h55});
		rd_regs(8'h85, '{8'h55});
		rd_regs(8'h05, '{8'h55, 8'h55});
	endtask : t_noinc
	// ==========
	// watchdog cuts a hang short
	initial begin
		repeat (100000) @(posedge core_clk_i);
		$display("[ERR] watchdog expected done seen hang");
		failures++;
		finish_test();
	end
	initial begin
		t_address();
		t_page();
		t_wrap();
		t_noinc();
		finish_test();
	end
endmodule : tb
